/* ecp_core.sv */
// ejector configuration, protection and part-present logic
// How it works
// - supply outside window sets status and event
// - undervoltage ignores inputs, part-present stays
// - undervoltage forces suction (NO) or off (NC)
// - inlet pressure write gives warning or error
// - zero correction only within three percent
// - output from limit, hysteresis, selectable polarity
// - output follows threshold crossings
// - signal type setting, sourcing after factory reset
// - pulse variant starts off, sucks on pulse
// - display unit affects display only
// - switch-off delay off, 10, 50, 200 ms
// - delayed signal feeds pin, data, display
// - normally closed inverts after the delay
// - saver blanks display after two idle minutes
// - button or error restores the display
// - saver enabled remotely blanks immediately
// - non-default PIN locks local menu writes
// - correct PIN unlocks for one idle minute
// - PIN never restricts remote access
// - three lock bits: remote, storage, local
// - local lock bit overrides the PIN
// - lock bits cleared only by remote write
`timescale 1ns/1ps
module ecp_core #(
    parameter int unsigned  MS_CYC  = ecp_pkg::MS_CYC,
    parameter ecp_pkg::ecp_variant_type VARIANT = ecp_pkg::VAR_NO,
    parameter logic [15:0]  INL_WLO = 16'h002d,
    parameter logic [15:0]  INL_WHI = 16'h003c,
    parameter logic [15:0]  INL_ELO = 16'h0023,
    parameter logic [15:0]  INL_EHI = 16'h0046
) (
    // clock and reset
    input  wire logic               sys_clk_i,
    input  wire logic               nrst_i,
    // measurements
    input  wire logic [15:0]        supply_dv_i,
    input  wire logic [15:0]        vacuum_i,
    input  wire logic signed [11:0] sensor_raw_i,
    input  wire logic               cal_req_i,
    // control signal inputs
    input  wire logic               suck_i,
    input  wire logic               blow_i,
    // local panel
    input  wire logic [2:0]         button_i,
    input  wire logic               loc_wr_i,
    input  wire logic [3:0]         loc_idx_i,
    input  wire logic [15:0]        loc_data_i,
    input  wire logic               pin_entry_i,
    input  wire logic [15:0]        pin_val_i,
    input  wire logic               fac_rst_i,
    // io-link parameter access
    input  wire logic               iol_wr_i,
    input  wire logic [3:0]         iol_idx_i,
    input  wire logic [15:0]        iol_data_i,
    input  wire logic               ds_req_i,
    // valve and part-present
    output logic                    suction_o,
    output logic                    blow_o,
    output logic                    part_present_o,
    output logic                    pd_part_o,
    output logic                    disp_part_o,
    // configuration readback
    output logic                    sig_sink_o,
    output logic [1:0]              disp_unit_o,
    output logic [15:0]             pin_o,
    output logic [2:0]              access_lock_o,
    output logic [11:0]             zero_offset_o,
    // status
    output logic                    display_on_o,
    output logic                    eco_dot_o,
    output logic                    supply_low_o,
    output logic                    supply_warn_o,
    output logic                    supply_event_o,
    output logic                    inlet_warn_o,
    output logic                    inlet_err_o,
    output logic                    cal_err_o,
    output logic                    menu_locked_o,
    output logic                    ds_go_o
);
    // ------------------------------------------------------------
    // configuration write arbitration
    // ------------------------------------------------------------
    logic [15:0] limit, hyst;
    logic        pol_nc, eco_en;
    logic [1:0]  dly_sel;
    logic        iol_ok, loc_ok, wr;
    logic [3:0]  widx;
    logic [15:0] wdat;

    always_comb begin
        // the lock register itself stays writable remotely
        iol_ok = iol_wr_i && (!access_lock_o[ecp_pkg::LK_IOL] ||
                 iol_idx_i == ecp_pkg::IDX_LOCK);
        loc_ok = loc_wr_i && !menu_locked_o &&
                 !access_lock_o[ecp_pkg::LK_LOC] &&
                 loc_idx_i != ecp_pkg::IDX_LOCK &&
                 loc_idx_i != ecp_pkg::IDX_INLET;
        wr   = iol_ok || loc_ok;
        widx = iol_ok ? iol_idx_i : loc_idx_i;
        wdat = iol_ok ? iol_data_i : loc_data_i;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            limit         <= ecp_pkg::LIM_RST;
            hyst          <= ecp_pkg::HYS_RST;
            pol_nc        <= ecp_pkg::POL_RST;
            sig_sink_o    <= ecp_pkg::STYPE_RST;
            disp_unit_o   <= ecp_pkg::UNIT_RST;
            dly_sel       <= ecp_pkg::DLY_RST;
            eco_en        <= ecp_pkg::ECO_RST;
            pin_o         <= ecp_pkg::PIN_RST;
            access_lock_o <= ecp_pkg::LOCK_RST;
        end else if (fac_rst_i) begin
            // locks and zero point survive a factory reset
            limit       <= ecp_pkg::LIM_RST;
            hyst        <= ecp_pkg::HYS_RST;
            pol_nc      <= ecp_pkg::POL_RST;
            sig_sink_o  <= ecp_pkg::STYPE_RST;
            disp_unit_o <= ecp_pkg::UNIT_RST;
            dly_sel     <= ecp_pkg::DLY_RST;
            eco_en      <= ecp_pkg::ECO_RST;
            pin_o       <= ecp_pkg::PIN_RST;
        end else if (wr) begin
            case (widx)
                ecp_pkg::IDX_LIM:   limit       <= wdat;
                ecp_pkg::IDX_HYS:   hyst        <= wdat;
                ecp_pkg::IDX_POL:   pol_nc      <= wdat[0];
                ecp_pkg::IDX_STYPE: sig_sink_o  <= wdat[0];
                ecp_pkg::IDX_UNIT:  disp_unit_o <= wdat[1:0];
                ecp_pkg::IDX_DLY:   dly_sel     <= wdat[1:0];
                ecp_pkg::IDX_ECO:   eco_en      <= wdat[0];
                ecp_pkg::IDX_PIN:   pin_o       <= wdat;
                ecp_pkg::IDX_LOCK:  access_lock_o <= wdat[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // millisecond tick
    // ------------------------------------------------------------
    logic [31:0] ms_cnt;
    logic        ms_tick;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ms_cnt  <= 32'h0;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= ms_cnt == MS_CYC - 1;
            ms_cnt  <= (ms_cnt == MS_CYC - 1) ? 32'h0 : ms_cnt + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // supply window and valve
    // ------------------------------------------------------------
    logic                   uv, oow, suck_q;
    ecp_pkg::ecp_valve_type vlv, next_vlv;

    assign uv  = supply_dv_i < ecp_pkg::UV_DV;
    assign oow = uv || supply_dv_i > ecp_pkg::OV_DV;

    always_comb begin
        next_vlv = vlv;
        if (uv) begin
            // pulse variant holds its state, inputs ignored
            if (VARIANT == ecp_pkg::VAR_NO) next_vlv = ecp_pkg::VLV_SUCK;
            if (VARIANT == ecp_pkg::VAR_NC) next_vlv = ecp_pkg::VLV_OFF;
        end else if (VARIANT != ecp_pkg::VAR_IMP) begin
            next_vlv = (suck_i && !blow_i) ? ecp_pkg::VLV_SUCK
                                           : ecp_pkg::VLV_OFF;
        end else begin
            unique case (vlv)
                ecp_pkg::VLV_OFF:
                    if (suck_i && !suck_q && !blow_i)
                        next_vlv = ecp_pkg::VLV_SUCK;
                ecp_pkg::VLV_SUCK:
                    if (blow_i) next_vlv = ecp_pkg::VLV_OFF;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vlv            <= ecp_pkg::VLV_OFF;
            suck_q         <= 1'b0;
            suction_o      <= 1'b0;
            blow_o         <= 1'b0;
            supply_low_o   <= 1'b0;
            supply_warn_o  <= 1'b0;
            supply_event_o <= 1'b0;
        end else begin
            vlv            <= next_vlv;
            suck_q         <= suck_i;
            suction_o      <= next_vlv == ecp_pkg::VLV_SUCK;
            blow_o         <= !uv && blow_i;
            supply_low_o   <= uv;
            supply_warn_o  <= oow;
            supply_event_o <= oow != supply_warn_o;
        end
    end

    // ------------------------------------------------------------
    // part-present with switch-off delay
    // ------------------------------------------------------------
    logic        pp_raw, pp_dly;
    logic [7:0]  dcnt, dly_ms;

    always_comb begin
        unique case (dly_sel)
            2'h1:    dly_ms = 8'(ecp_pkg::DLY10_MS);
            2'h2:    dly_ms = 8'(ecp_pkg::DLY50_MS);
            2'h3:    dly_ms = 8'(ecp_pkg::DLY200_MS);
            default: dly_ms = 8'h0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pp_raw <= 1'b0;
            pp_dly <= 1'b0;
            dcnt   <= 8'h0;
        end else begin
            // hysteresis compared widened so a large value cannot wrap
            if (vacuum_i >= limit) pp_raw <= 1'b1;
            else if ({1'b0, vacuum_i} + {1'b0, hyst} < {1'b0, limit})
                pp_raw <= 1'b0;
            if (pp_raw) begin
                pp_dly <= 1'b1;
                dcnt   <= 8'h0;
            end else if (dcnt >= dly_ms) begin
                pp_dly <= 1'b0;
            end else if (ms_tick) begin
                dcnt <= dcnt + 8'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            part_present_o <= 1'b0;
            pd_part_o      <= 1'b0;
            disp_part_o    <= 1'b0;
        end else begin
            part_present_o <= pp_dly ^ pol_nc;
            pd_part_o      <= pp_dly;
            disp_part_o    <= pp_dly;
        end
    end

    // ------------------------------------------------------------
    // zero point, inlet pressure, data storage
    // ------------------------------------------------------------
    localparam logic signed [11:0] ZLIM = 12'(ecp_pkg::ZERO_LIM);
    logic zero_ok;

    assign zero_ok = sensor_raw_i >= -ZLIM && sensor_raw_i <= ZLIM;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            zero_offset_o <= 12'h0;
            cal_err_o     <= 1'b0;
            inlet_warn_o  <= 1'b0;
            inlet_err_o   <= 1'b0;
            ds_go_o       <= 1'b0;
        end else begin
            if (cal_req_i) begin
                cal_err_o <= !zero_ok;
                if (zero_ok) zero_offset_o <= sensor_raw_i;
            end
            if (iol_ok && iol_idx_i == ecp_pkg::IDX_INLET) begin
                inlet_warn_o <= iol_data_i < INL_WLO ||
                                iol_data_i > INL_WHI;
                inlet_err_o  <= iol_data_i < INL_ELO ||
                                iol_data_i > INL_EHI;
            end
            ds_go_o <= ds_req_i && !access_lock_o[ecp_pkg::LK_DS];
        end
    end

    // ------------------------------------------------------------
    // display saver
    // ------------------------------------------------------------
    logic [16:0] eco_cnt;
    logic        err_any, err_q, eco_now;

    assign err_any = cal_err_o || inlet_err_o || supply_warn_o;
    assign eco_now = iol_ok && iol_idx_i == ecp_pkg::IDX_ECO &&
                     iol_data_i[0];

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            eco_cnt      <= 17'h0;
            err_q        <= 1'b0;
            display_on_o <= 1'b1;
            eco_dot_o    <= 1'b0;
        end else begin
            err_q <= err_any;
            if (|button_i || (err_any && !err_q) || !eco_en) begin
                eco_cnt      <= 17'h0;
                display_on_o <= 1'b1;
                eco_dot_o    <= 1'b0;
            end
            if (eco_now) begin
                display_on_o <= 1'b0;
                eco_dot_o    <= 1'b1;
            end else if (eco_en && !(|button_i) && display_on_o) begin
                if (eco_cnt == 17'(ecp_pkg::ECO_MS)) begin
                    display_on_o <= 1'b0;
                    eco_dot_o    <= 1'b1;
                end else if (ms_tick) begin
                    eco_cnt <= eco_cnt + 17'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // PIN unlock window
    // ------------------------------------------------------------
    logic [15:0] pin_cnt;
    logic        unlocked;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            unlocked      <= 1'b0;
            pin_cnt       <= 16'h0;
            menu_locked_o <= 1'b0;
        end else begin
            if (pin_entry_i && pin_val_i == pin_o) begin
                unlocked <= 1'b1;
                pin_cnt  <= 16'h0;
            end else if (loc_ok) begin
                pin_cnt <= 16'h0;
            end else if (unlocked && pin_cnt == 16'(ecp_pkg::PIN_MS)) begin
                unlocked <= 1'b0;
            end else if (unlocked && ms_tick) begin
                pin_cnt <= pin_cnt + 16'h1;
            end
            // pin entry never lifts the lock bit
            menu_locked_o <= access_lock_o[ecp_pkg::LK_LOC] ||
                (pin_o != ecp_pkg::PIN_RST && !unlocked);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_pin_ok;
        pin_entry_i && pin_val_i == pin_o &&
        !access_lock_o[ecp_pkg::LK_LOC] &&
        !(iol_wr_i && iol_idx_i == ecp_pkg::IDX_LOCK);
    endsequence

    a_uv_force: assert property (uv && VARIANT != ecp_pkg::VAR_IMP
        |=> suction_o == (VARIANT == ecp_pkg::VAR_NO))
        else $error("undervoltage valve state wrong");
    a_supply_event: assert property ($changed(supply_warn_o) |->
        supply_event_o)
        else $error("supply change without event");
    a_cal_reject: assert property (cal_req_i && !zero_ok |=>
        cal_err_o && $stable(zero_offset_o))
        else $error("out of range zero accepted");
    a_iol_lock: assert property (iol_wr_i && access_lock_o[0] &&
        iol_idx_i == ecp_pkg::IDX_LIM && !loc_wr_i && !fac_rst_i
        |=> $stable(limit))
        else $error("locked remote write took effect");
    a_loc_lock: assert property (loc_wr_i && access_lock_o[2] &&
        !iol_wr_i && !fac_rst_i |=> $stable(limit))
        else $error("locked local write took effect");
    a_lock_clear: assert property (!iol_wr_i |=>
        $stable(access_lock_o))
        else $error("lock bits changed without remote write");
    a_ds_block: assert property (ds_req_i && access_lock_o[1] |=>
        !ds_go_o)
        else $error("data storage ran while locked");
    a_eco_now: assert property (eco_now |=>
        !display_on_o && eco_dot_o)
        else $error("remote saver did not blank display");
    a_pp_polarity: assert property (part_present_o ==
        (pd_part_o ^ $past(pol_nc)))
        else $error("output polarity wrong");
    a_pin_unlock: assert property (s_pin_ok |-> ##2 !menu_locked_o)
        else $error("correct pin did not unlock menu");
endmodule

/* ecp_core_tb.sv */
// self-checking bench for the ejector configuration block
`timescale 1ns/1ps
module ecp_core_tb;
    localparam int MSC = 4;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [15:0] supply_dv_i = 16'h00f0;
    logic [15:0] vacuum_i = 16'h0000;
    logic signed [11:0] sensor_raw_i = 12'sh000;
    logic cal_req_i = 1'b0;
    logic suck_i = 1'b0;
    logic blow_i = 1'b0;
    logic fac_rst_i = 1'b0;
    logic iol_wr_i, loc_wr_i, pin_entry_i, ds_req_i;
    logic [3:0] iol_idx_i, loc_idx_i;
    logic [15:0] iol_data_i, loc_data_i, pin_val_i;
    logic [2:0] button_i;
    logic suction_o, blow_o, part_present_o, pd_part_o, disp_part_o;
    logic sig_sink_o, display_on_o, eco_dot_o, supply_low_o;
    logic supply_warn_o, supply_event_o, inlet_warn_o, inlet_err_o;
    logic cal_err_o, menu_locked_o, ds_go_o;
    logic imp_suction;
    logic [1:0] disp_unit_o;
    logic [15:0] pin_o;
    logic [2:0] access_lock_o;
    logic [11:0] zero_offset_o;
    int failures = 0;
    int checks_done = 0;
    logic [15:0] sup [4] = '{16'h00bf, 16'h00c0, 16'h0109, 16'h0108};
    int dl [4] = '{0, 10, 50, 200};
    logic signed [11:0] raw [4] = '{12'sd30, -12'sd31, -12'sd30, 12'sd31};
    logic [15:0] inl [5] = '{16'h30, 16'h28, 16'h20, 16'h40, 16'h50};
    logic [1:0] inx [5] = '{2'h0, 2'h1, 2'h3, 2'h1, 2'h3};
    logic [11:0] zexp;

    ecp_core #(.MS_CYC(MSC), .VARIANT(ecp_pkg::VAR_NO)) ecp_core_i (.*);
    // pulse variant shares the stimulus; only its valve is observed
    ecp_core #(.MS_CYC(MSC), .VARIANT(ecp_pkg::VAR_IMP)) ecp_core_imp_i (
        .*, .suction_o(imp_suction), .blow_o(), .part_present_o(),
        .pd_part_o(), .disp_part_o(), .sig_sink_o(), .disp_unit_o(),
        .pin_o(), .access_lock_o(), .zero_offset_o(), .display_on_o(),
        .eco_dot_o(), .supply_low_o(), .supply_warn_o(),
        .supply_event_o(), .inlet_warn_o(), .inlet_err_o(),
        .cal_err_o(), .menu_locked_o(), .ds_go_o()
    );
    ecp_partner ecp_partner_i (
        .sys_clk_i   (sys_clk_i),
        .iol_wr_o    (iol_wr_i),
        .iol_idx_o   (iol_idx_i),
        .iol_data_o  (iol_data_i),
        .ds_req_o    (ds_req_i),
        .loc_wr_o    (loc_wr_i),
        .loc_idx_o   (loc_idx_i),
        .loc_data_o  (loc_data_i),
        .pin_entry_o (pin_entry_i),
        .pin_val_o   (pin_val_i),
        .button_o    (button_i)
    );
    always #25 sys_clk_i = ~sys_clk_i;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic op(input int k, input logic [3:0] i,
                      input logic [15:0] d);
        ecp_partner_i.send(k, i, d);
        tick(2);
    endtask

    // watchdog: the whole run needs about 1300 cycles
    initial begin
        #(20000 * 50);
        failures++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        tick(2);
        check("sink", sig_sink_o, 1'h0);
        check("imp", imp_suction, 1'h0);
        check("locks", access_lock_o, 3'h0);
        check("mlock", menu_locked_o, 1'h0);
        @(posedge sys_clk_i);
        blow_i <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk_i);
            supply_dv_i <= sup[k];
            tick(1);
            check("warn", supply_warn_o, 16'(k % 2 == 0));
            check("event", supply_event_o, 1'h1);
            check("low", supply_low_o, 16'(k == 0));
            tick(2);
            check("event", supply_event_o, 1'h0);
            check("suck", suction_o, 16'(k == 0));
            check("blow", blow_o, 16'(k != 0));
        end
        @(posedge sys_clk_i);
        blow_i <= 1'b0;
        suck_i <= 1'b1;
        tick(3);
        check("suck", suction_o, 1'h1);
        check("imp", imp_suction, 1'h1);
        for (int k = 0; k < 4; k++) begin
            op(0, 4'h5, 16'(k));
            op(0, 4'h2, 16'(k % 2));
            @(posedge sys_clk_i);
            vacuum_i <= 16'h0230;
            tick(4);
            check("pd", pd_part_o, 1'h1);
            check("disp", disp_part_o, 1'h1);
            check("out", part_present_o, 16'(k % 2 == 0));
            @(posedge sys_clk_i);
            vacuum_i <= 16'h0221;
            tick(4);
            check("hys", pd_part_o, 1'h1);
            @(posedge sys_clk_i);
            vacuum_i <= 16'h0200;
            if (k > 0) begin
                tick(dl[k] * MSC - 6);
                check("hold", pd_part_o, 1'h1);
                check("out", part_present_o, 16'(k % 2 == 0));
            end
            tick(20);
            check("pd", pd_part_o, 1'h0);
            check("disp", disp_part_o, 1'h0);
            check("out", part_present_o, 16'(k % 2));
        end
        op(0, 4'h7, 16'h1234);
        tick(1);
        check("pin", pin_o, 16'h1234);
        check("mlock", menu_locked_o, 1'h1);
        op(1, 4'h4, 16'h0002);
        check("unit", disp_unit_o, 2'h0);
        op(2, 4'h0, 16'h1111);
        tick(1);
        check("mlock", menu_locked_o, 1'h1);
        op(2, 4'h0, 16'h1234);
        tick(1);
        check("mlock", menu_locked_o, 1'h0);
        op(1, 4'h4, 16'h0001);
        check("unit", disp_unit_o, 2'h1);
        op(0, 4'h4, 16'h0003);
        check("unit", disp_unit_o, 2'h3);
        op(0, 4'h7, 16'h0000);
        op(0, 4'h8, 16'h0007);
        tick(1);
        check("locks", access_lock_o, 3'h7);
        check("mlock", menu_locked_o, 1'h1);
        op(0, 4'h4, 16'h0000);
        check("unit", disp_unit_o, 2'h3);
        ecp_partner_i.send(3, 4'h0, 16'h0000);
        #1;
        check("dsgo", ds_go_o, 1'h0);
        op(2, 4'h0, 16'h0000);
        tick(1);
        check("mlock", menu_locked_o, 1'h1);
        op(1, 4'h8, 16'h0000);
        check("locks", access_lock_o, 3'h7);
        op(0, 4'h8, 16'h0000);
        tick(1);
        check("locks", access_lock_o, 3'h0);
        check("mlock", menu_locked_o, 1'h0);
        ecp_partner_i.send(3, 4'h0, 16'h0000);
        #1;
        check("dsgo", ds_go_o, 1'h1);
        op(0, 4'h6, 16'h0001);
        check("lit", display_on_o, 1'h0);
        check("dot", eco_dot_o, 1'h1);
        op(4, 4'h0, 16'h0000);
        tick(1);
        check("lit", display_on_o, 1'h1);
        zexp = 12'h000;
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk_i);
            sensor_raw_i <= raw[k];
            cal_req_i <= 1'b1;
            @(posedge sys_clk_i);
            cal_req_i <= 1'b0;
            tick(2);
            if (k % 2 == 0) zexp = raw[k];
            check("calerr", cal_err_o, 16'(k % 2));
            check("zero", zero_offset_o, zexp);
        end
        for (int k = 0; k < 5; k++) begin
            op(0, 4'h9, inl[k]);
            check("inlet", {inlet_err_o, inlet_warn_o}, inx[k]);
        end
        op(0, 4'h3, 16'h0001);
        check("sink", sig_sink_o, 1'h1);
        @(posedge sys_clk_i);
        fac_rst_i <= 1'b1;
        @(posedge sys_clk_i);
        fac_rst_i <= 1'b0;
        tick(2);
        check("sink", sig_sink_o, 1'h0);
        end_of_test();
    end
endmodule

/* ecp_partner.sv */
// far-side model: io-link master and local panel with buttons
`timescale 1ns/1ps
module ecp_partner (
    // clock
    input  wire logic        sys_clk_i,
    // io-link master
    output logic             iol_wr_o,
    output logic [3:0]       iol_idx_o,
    output logic [15:0]      iol_data_o,
    output logic             ds_req_o,
    // local panel
    output logic             loc_wr_o,
    output logic [3:0]       loc_idx_o,
    output logic [15:0]      loc_data_o,
    output logic             pin_entry_o,
    output logic [15:0]      pin_val_o,
    output logic [2:0]       button_o
);
    initial begin
        {iol_wr_o, ds_req_o, loc_wr_o, pin_entry_o} = 4'h0;
        {iol_idx_o, loc_idx_o} = 8'h0;
        {iol_data_o, loc_data_o, pin_val_o} = 48'h0;
        button_o = 3'h0;
    end
    // k: 0 remote write, 1 local write, 2 pin entry, 3 storage, 4 button
    task automatic send(input int k, input logic [3:0] i,
                        input logic [15:0] d);
        @(posedge sys_clk_i);
        iol_idx_o  <= i;
        loc_idx_o  <= i;
        iol_data_o <= d;
        loc_data_o <= d;
        pin_val_o  <= d;
        iol_wr_o    <= (k == 0);
        loc_wr_o    <= (k == 1);
        pin_entry_o <= (k == 2);
        ds_req_o    <= (k == 3);
        button_o    <= (k == 4) ? 3'h1 : 3'h0;
        @(posedge sys_clk_i);
        {iol_wr_o, ds_req_o, loc_wr_o, pin_entry_o} <= 4'h0;
        button_o <= 3'h0;
        // released fields turn over so stale values are never relied on
        iol_data_o <= ~d;
        loc_data_o <= ~d;
        pin_val_o  <= ~d;
    endtask
endmodule

/* ecp_pkg.sv */
// shared constants and types of the ejector configuration block
package ecp_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int MS_NS  = 1000000;
    localparam int MS_CYC = (MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int DLY10_MS  = 10;
    localparam int DLY50_MS  = 50;
    localparam int DLY200_MS = 200;
    localparam int ECO_MIN   = 2;
    localparam int ECO_MS    = ECO_MIN * 60000;
    localparam int PIN_MIN   = 1;
    localparam int PIN_MS    = PIN_MIN * 60000;
    // ------------------------------------------------------------
    // limits (supply in units of 0.1 V)
    // ------------------------------------------------------------
    localparam logic [15:0] UV_DV    = 16'h00c0;
    localparam logic [15:0] OV_DV    = 16'h0108;
    localparam int          ZERO_PCT = 3;
    localparam int          ZERO_FS  = 1000;
    localparam int          ZERO_LIM = ZERO_FS * ZERO_PCT / 100;
    // ------------------------------------------------------------
    // parameter indices
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_LIM   = 4'h0;
    localparam logic [3:0] IDX_HYS   = 4'h1;
    localparam logic [3:0] IDX_POL   = 4'h2;
    localparam logic [3:0] IDX_STYPE = 4'h3;
    localparam logic [3:0] IDX_UNIT  = 4'h4;
    localparam logic [3:0] IDX_DLY   = 4'h5;
    localparam logic [3:0] IDX_ECO   = 4'h6;
    localparam logic [3:0] IDX_PIN   = 4'h7;
    localparam logic [3:0] IDX_LOCK  = 4'h8;
    localparam logic [3:0] IDX_INLET = 4'h9;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int LK_IOL = 0;
    localparam int LK_DS  = 1;
    localparam int LK_LOC = 2;
    localparam logic [15:0] LIM_RST   = 16'h0226;
    localparam logic [15:0] HYS_RST   = 16'h000a;
    localparam logic        POL_RST   = 1'b0;
    localparam logic        STYPE_RST = 1'b0;
    localparam logic [1:0]  UNIT_RST  = 2'h0;
    localparam logic [1:0]  DLY_RST   = 2'h0;
    localparam logic        ECO_RST   = 1'b0;
    localparam logic [15:0] PIN_RST   = 16'h0000;
    localparam logic [2:0]  LOCK_RST  = 3'h0;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic {VLV_OFF = 1'b0, VLV_SUCK = 1'b1} ecp_valve_type;
    typedef enum logic [1:0] {
        VAR_NO  = 2'h0,
        VAR_NC  = 2'h1,
        VAR_IMP = 2'h3
    } ecp_variant_type;
endpackage
